// *** rtl/pic_cell.sv ***
// Paired pad slice cell: pad drive, input delay and SDR/DDR/gearbox capture
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

module pic_cell
    import pic_pkg::*;
#(
    parameter bit HAS_GEARBOX = 1'b1,
    parameter bit DIFF_OUT_OK = 1'b1
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [1:0]  pad_in_data_i,
    input  wire logic        strobe_i,
    input  wire logic        global_set_reset_n_i,
    output logic      [1:0]  pad_out_o,
    output logic      [1:0]  pad_tristate_ctl_o,
    output logic      [1:0]  raw_in_to_core_o,
    output logic             in_clock_tap_o,
    output logic             strobe_delay_in_o,
    output logic      [1:0]  sdr_captured_in_o,
    output logic      [3:0]  ddr_captured_in_o,
    output logic      [1:0]  gearbox_pipe_rise_o,
    output logic      [1:0]  gearbox_pipe_fall_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register file over the classic bus
    logic [15:0] ctrl;
    logic [15:0] dly_reg;
    logic [15:0] out_reg;
    logic [15:0] next_ctrl;
    logic [15:0] next_dly_reg;
    logic [15:0] next_out_reg;
    logic [31:0] next_dat;
    logic        next_ack;
    logic [15:0] lane;
    logic        wr;
    logic [11:0] in_status;

    assign lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

    // One wait state; unmapped reads return zero, writes are dropped
    always_comb
    begin
        next_ctrl    = ctrl;
        next_dly_reg = dly_reg;
        next_out_reg = out_reg;
        next_ack     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_dat     = 32'h00000000;
        if (wb_adr_i == PIC_ADDR_CTRL)
        begin
            next_dat = {16'h0000, ctrl};
            if (wr)
                next_ctrl = (ctrl & ~(lane & PIC_MASK_CTRL))
                          | (wb_dat_i[15:0] & lane & PIC_MASK_CTRL);
        end
        else if (wb_adr_i == PIC_ADDR_DELAY)
        begin
            next_dat = {16'h0000, dly_reg};
            if (wr)
                next_dly_reg = (dly_reg & ~(lane & PIC_MASK_DELAY))
                             | (wb_dat_i[15:0] & lane & PIC_MASK_DELAY);
        end
        else if (wb_adr_i == PIC_ADDR_OUT)
        begin
            next_dat = {16'h0000, out_reg};
            if (wr)
                next_out_reg = (out_reg & ~(lane & PIC_MASK_OUT))
                             | (wb_dat_i[15:0] & lane & PIC_MASK_OUT);
        end
        else if (wb_adr_i == PIC_ADDR_INDATA)
            next_dat = {20'h00000, in_status};
    end

    // Bus registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl     <= PIC_RST_CTRL;
            dly_reg  <= PIC_RST_DELAY;
            out_reg  <= PIC_RST_OUT;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            ctrl     <= next_ctrl;
            dly_reg  <= next_dly_reg;
            out_reg  <= next_out_reg;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control decode
    pic_mode_type mode;
    logic         ce;
    logic         pol;
    logic         diff;
    logic         clr;

    assign mode = pic_mode_type'(ctrl[PIC_CTRL_MODE_LSB +: 2]);
    assign ce   = ctrl[PIC_CTRL_CE];
    assign pol  = ctrl[PIC_CTRL_POL];
    assign diff = ctrl[PIC_CTRL_DIFF];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stages feed only the second stages
    logic [1:0] pad_m;
    logic [1:0] pad_s;
    logic       stb_m;
    logic       stb_s;
    logic       stb_d;
    logic       gsr_m;
    logic       gsr_s;
    logic       rise_ev;
    logic       fall_ev;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pad_m <= 2'h0;
            pad_s <= 2'h0;
            stb_m <= 1'b0;
            stb_s <= 1'b0;
            stb_d <= 1'b0;
            gsr_m <= 1'b1;
            gsr_s <= 1'b1;
        end
        else
        begin
            pad_m <= pad_in_data_i;
            pad_s <= pad_m;
            stb_m <= strobe_i;
            stb_s <= stb_m;
            stb_d <= stb_s;
            gsr_m <= global_set_reset_n_i;
            gsr_s <= gsr_m;
        end
    end

    // Strobe edges seen by the system clock
    assign rise_ev = stb_s & ~stb_d;
    assign fall_ev = ~stb_s & stb_d;
    // Local or global set/reset clears the data flops
    assign clr = ctrl[PIC_CTRL_LSR] | ~gsr_s;

    ////////////////////////////////////////////////////////////////////////
    // Per slice: delay line, SDR and DDR capture
    logic [1:0] dly_out;
    logic [1:0] rise_q;
    logic [1:0] fall_q;

    generate
        for (genvar s = 0; s < 2; s++)
        begin : g_slice
            logic [PIC_DLY_TAPS-1:0] line;
            logic [PIC_DLY_TAPS-1:0] next_line;
            logic                    src;
            logic                    next_rise;
            logic                    next_fall;
            logic                    next_sdr;
            logic [1:0]              next_ddr;

            // A joined pair listens to its true pad only
            assign src = (s == 1 && diff) ? pad_s[0] : pad_s[s];

            // Delay taps in system clock steps; code 0 is one cycle
            always_comb
            begin
                next_line = {line[PIC_DLY_TAPS-2:0], src};
                if (!ctrl[PIC_CTRL_DLY_EN])
                    dly_out[s] = src;
                else if (ctrl[PIC_CTRL_DLY_DYN])
                    dly_out[s] = line[dly_reg[3:0]];
                else
                    dly_out[s] = line[PIC_FIX_TAP];
            end

            // Capture next values, gated by enable
            always_comb
            begin
                next_rise = rise_q[s];
                next_fall = fall_q[s];
                next_sdr  = sdr_captured_in_o[s];
                next_ddr  = ddr_captured_in_o[2*s +: 2];
                if (clr)
                begin
                    next_rise = 1'b0;
                    next_fall = 1'b0;
                    next_sdr  = 1'b0;
                    next_ddr  = 2'h0;
                end
                else if (ce)
                begin
                    if (mode == PIC_MODE_SDR)
                        next_sdr = dly_out[s];
                    if (rise_ev)
                        next_rise = dly_out[s];
                    if (fall_ev)
                        next_fall = dly_out[s];
                    // Pair leaves on the fall edge or the next rise edge
                    if (mode == PIC_MODE_DDR && !pol && fall_ev)
                        next_ddr = {dly_out[s], rise_q[s]};
                    if (mode == PIC_MODE_DDR && pol && rise_ev)
                        next_ddr = {fall_q[s], rise_q[s]};
                end
            end

            // Slice registers
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    line                      <= '0;
                    rise_q[s]                 <= 1'b0;
                    fall_q[s]                 <= 1'b0;
                    sdr_captured_in_o[s]      <= 1'b0;
                    ddr_captured_in_o[2*s+:2] <= 2'h0;
                end
                else
                begin
                    line                      <= next_line;
                    rise_q[s]                 <= next_rise;
                    fall_q[s]                 <= next_fall;
                    sdr_captured_in_o[s]      <= next_sdr;
                    ddr_captured_in_o[2*s+:2] <= next_ddr;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Gearbox: two strobe periods of the true pad become four streams
    logic       gb_ph;
    logic       gb_r0;
    logic       gb_f0;
    logic       next_gb_ph;
    logic       next_gb_r0;
    logic       next_gb_f0;
    logic [1:0] next_gb_rise;
    logic [1:0] next_gb_fall;

    always_comb
    begin
        next_gb_ph   = gb_ph;
        next_gb_r0   = gb_r0;
        next_gb_f0   = gb_f0;
        next_gb_rise = gearbox_pipe_rise_o;
        next_gb_fall = gearbox_pipe_fall_o;
        if (clr || !HAS_GEARBOX || mode != PIC_MODE_GEARBOX)
        begin
            next_gb_ph   = 1'b0;
            next_gb_r0   = 1'b0;
            next_gb_f0   = 1'b0;
            next_gb_rise = clr || !HAS_GEARBOX ? 2'h0 : next_gb_rise;
            next_gb_fall = clr || !HAS_GEARBOX ? 2'h0 : next_gb_fall;
        end
        else if (ce && fall_ev)
        begin
            next_gb_ph = ~gb_ph;
            if (!gb_ph)
            begin
                next_gb_r0 = rise_q[0];
                next_gb_f0 = dly_out[0];
            end
            else
            begin
                next_gb_rise = {rise_q[0], gb_r0};
                next_gb_fall = {dly_out[0], gb_f0};
            end
        end
    end

    // Gearbox registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gb_ph               <= 1'b0;
            gb_r0               <= 1'b0;
            gb_f0               <= 1'b0;
            gearbox_pipe_rise_o <= 2'h0;
            gearbox_pipe_fall_o <= 2'h0;
        end
        else
        begin
            gb_ph               <= next_gb_ph;
            gb_r0               <= next_gb_r0;
            gb_f0               <= next_gb_f0;
            gearbox_pipe_rise_o <= next_gb_rise;
            gearbox_pipe_fall_o <= next_gb_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad drive and bypass taps
    logic       out_ph;
    logic       next_out_ph;
    logic [1:0] next_pad;
    logic [1:0] next_oe;
    logic       tri_v;

    // DDR output alternates halves per enabled system clock cycle
    always_comb
    begin
        next_out_ph = ce ? ~out_ph : out_ph;
        tri_v = out_reg[PIC_OUT_TRI_SDR];
        if (ctrl[PIC_CTRL_OUT_DDR])
            tri_v = out_ph ? out_reg[PIC_OUT_TRI_FALL]
                           : out_reg[PIC_OUT_TRI_RISE];
        next_pad[0] = out_reg[PIC_OUT_A_FALL];
        next_pad[1] = out_reg[PIC_OUT_B_FALL];
        if (ctrl[PIC_CTRL_OUT_DDR] && !out_ph)
        begin
            next_pad[0] = out_reg[PIC_OUT_A_RISE];
            next_pad[1] = out_reg[PIC_OUT_B_RISE];
        end
        // Complement pad drives the inverse of the true pad only where allowed
        if (diff && DIFF_OUT_OK)
            next_pad[1] = ~next_pad[0];
        next_oe = {2{~tri_v}};
        if (clr)
        begin
            next_out_ph = 1'b0;
            next_pad    = 2'h0;
            next_oe     = 2'h0;
        end
        else if (!ce)
        begin
            next_pad = pad_out_o;
            next_oe  = pad_tristate_ctl_o;
        end
    end

    // Output and bypass registers; bypass ignores mode and enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_ph             <= 1'b0;
            pad_out_o          <= 2'h0;
            pad_tristate_ctl_o <= 2'h0;
            raw_in_to_core_o   <= 2'h0;
            in_clock_tap_o     <= 1'b0;
            strobe_delay_in_o  <= 1'b0;
        end
        else
        begin
            out_ph             <= next_out_ph;
            pad_out_o          <= next_pad;
            pad_tristate_ctl_o <= next_oe;
            raw_in_to_core_o   <= pad_s;
            in_clock_tap_o     <= pad_s[0];
            strobe_delay_in_o  <= pad_s[0];
        end
    end

    assign in_status = {gearbox_pipe_fall_o, gearbox_pipe_rise_o,
                        ddr_captured_in_o, sdr_captured_in_o,
                        raw_in_to_core_o};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_sdr;
        @(posedge clk_i) disable iff (rst_i)
        (mode == PIC_MODE_SDR && ce && !clr) |=>
            sdr_captured_in_o[0] == $past(dly_out[0]);
    endproperty
    a_sdr: assert property (p_sdr)
        else $error("SDR capture missed");

    property p_rise;
        @(posedge clk_i) disable iff (rst_i)
        (rise_ev && ce && !clr) |=> rise_q[0] == $past(dly_out[0]);
    endproperty
    a_rise: assert property (p_rise)
        else $error("Rise capture missed");

    property p_pair_fall;
        @(posedge clk_i) disable iff (rst_i)
        (mode == PIC_MODE_DDR && !pol && fall_ev && ce && !clr) |=>
            ddr_captured_in_o[1:0] == {$past(dly_out[0]), $past(rise_q[0])};
    endproperty
    a_pair_fall: assert property (p_pair_fall)
        else $error("DDR pair split");

    property p_pol_hold;
        @(posedge clk_i) disable iff (rst_i)
        (mode == PIC_MODE_DDR && pol && !rise_ev && !clr) |=>
            $stable(ddr_captured_in_o);
    endproperty
    a_pol_hold: assert property (p_pol_hold)
        else $error("DDR retime on wrong edge");

    property p_ce;
        @(posedge clk_i) disable iff (rst_i)
        (!ce && !clr) |=> $stable(pad_out_o) && $stable(rise_q);
    endproperty
    a_ce: assert property (p_ce)
        else $error("Enable ignored");

    property p_gsr;
        @(posedge clk_i) disable iff (rst_i)
        !gsr_s |=> pad_tristate_ctl_o == 2'h0 && ddr_captured_in_o == 4'h0;
    endproperty
    a_gsr: assert property (p_gsr)
        else $error("Global reset ignored");

    property p_gb;
        @(posedge clk_i) disable iff (rst_i)
        ((!HAS_GEARBOX || mode != PIC_MODE_GEARBOX) && !clr) |=>
            $stable(gearbox_pipe_rise_o) && $stable(gearbox_pipe_fall_o);
    endproperty
    a_gb: assert property (p_gb)
        else $error("Gearbox output on plain edge");

    property p_raw;
        @(posedge clk_i) disable iff (rst_i)
        ##1 raw_in_to_core_o == $past(pad_s, 1);
    endproperty
    a_raw: assert property (p_raw)
        else $error("Bypass path stale");

    property p_diff;
        @(posedge clk_i) disable iff (rst_i)
        (diff && DIFF_OUT_OK && ce && !clr) |=> pad_out_o[1] != pad_out_o[0];
    endproperty
    a_diff: assert property (p_diff)
        else $error("Complement pad not inverted");

endmodule

// *** rtl/pic_pkg.sv ***
// Package for the paired pad slice input capture cell
package pic_pkg;
    // Capture modes of the input path
    typedef enum logic [1:0]
    {
        PIC_MODE_BYPASS  = 2'h0,
        PIC_MODE_SDR     = 2'h1,
        PIC_MODE_DDR     = 2'h2,
        PIC_MODE_GEARBOX = 2'h3
    } pic_mode_type;

    // Register byte addresses
    localparam logic [3:0]  PIC_ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  PIC_ADDR_DELAY  = 4'h4;
    localparam logic [3:0]  PIC_ADDR_OUT    = 4'h8;
    localparam logic [3:0]  PIC_ADDR_INDATA = 4'hC;

    // Writable bits per register
    localparam logic [15:0] PIC_MASK_CTRL  = 16'h01FF;
    localparam logic [15:0] PIC_MASK_DELAY = 16'h000F;
    localparam logic [15:0] PIC_MASK_OUT   = 16'h007F;

    // Reset values
    localparam logic [15:0] PIC_RST_CTRL  = 16'h0020;
    localparam logic [15:0] PIC_RST_DELAY = 16'h0000;
    localparam logic [15:0] PIC_RST_OUT   = 16'h0070;

    // Control register fields
    localparam int PIC_CTRL_MODE_LSB = 0;
    localparam int PIC_CTRL_DLY_EN   = 2;
    localparam int PIC_CTRL_DLY_DYN  = 3;
    localparam int PIC_CTRL_POL      = 4;
    localparam int PIC_CTRL_CE       = 5;
    localparam int PIC_CTRL_LSR      = 6;
    localparam int PIC_CTRL_DIFF     = 7;
    localparam int PIC_CTRL_OUT_DDR  = 8;

    // Output register fields
    localparam int PIC_OUT_A_RISE   = 0;
    localparam int PIC_OUT_A_FALL   = 1;
    localparam int PIC_OUT_B_RISE   = 2;
    localparam int PIC_OUT_B_FALL   = 3;
    localparam int PIC_OUT_TRI_SDR  = 4;
    localparam int PIC_OUT_TRI_RISE = 5;
    localparam int PIC_OUT_TRI_FALL = 6;

    // Delay line geometry
    localparam int         PIC_DLY_TAPS = 16;
    localparam logic [3:0] PIC_FIX_TAP  = 4'h3;
endpackage

// *** verif/pic_ddr_source.sv ***
// Pad-side source model: static levels and DDR read bursts with a strobe
`timescale 1ns/1ps

module pic_ddr_source
(
    input  wire logic       clk_i,
    output logic            strobe_o,
    output logic      [1:0] pad_o
);
    // The strobe stands still low between bursts, as a memory's does
    initial
    begin
        strobe_o = 1'b0;
        pad_o    = 2'h0;
    end

    //////////////////////////////////////////////////////////////////////
    // Static level on both pads, launched just after a clock edge
    task automatic hold(input logic [1:0] v);
        @(posedge clk_i);
        pad_o <= v;
    endtask

    // One burst of n strobe periods at 80 ns, each word centred on its edge
    task automatic burst(input logic [15:0] rw, input logic [15:0] fw,
                         input int n);
        #3;
        for (int k = 0; k < n; k++)
        begin
            pad_o = rw[2*k +: 2];
            #20;
            strobe_o = 1'b1;
            #20;
            pad_o = fw[2*k +: 2];
            #20;
            strobe_o = 1'b0;
            #20;
        end
        // Released pads show the inverse, so a stale word cannot pass
        pad_o = ~pad_o;
    endtask
endmodule

// *** verif/test_pic_cell.sv ***
// Self-checking bench for the paired pad slice capture cell
`timescale 1ns/1ps

module test_pic_cell
    import pic_pkg::*;
;
    logic        clk_i                = 1'b0;
    logic        rst_i                = 1'b1;
    logic        wb_cyc_i             = 1'b0;
    logic        wb_stb_i             = 1'b0;
    logic        wb_we_i              = 1'b0;
    logic [3:0]  wb_adr_i             = 4'h0;
    logic [3:0]  wb_sel_i             = 4'hF;
    logic [31:0] wb_dat_i             = 32'h00000000;
    logic        global_set_reset_n_i = 1'b1;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [1:0]  pad_in_data_i;
    logic        strobe_i;
    logic [1:0]  pad_out_o;
    logic [1:0]  pad_tristate_ctl_o;
    logic [1:0]  raw_in_to_core_o;
    logic        in_clock_tap_o;
    logic        strobe_delay_in_o;
    logic [1:0]  sdr_captured_in_o;
    logic [3:0]  ddr_captured_in_o;
    logic [1:0]  gearbox_pipe_rise_o;
    logic [1:0]  gearbox_pipe_fall_o;
    logic [15:0] rdata;
    int          fails                = 0;
    int          samples_checked      = 0;

    // 100 MHz system clock
    always #5 clk_i = ~clk_i;

    pic_cell #(.HAS_GEARBOX(1'b1), .DIFF_OUT_OK(1'b1)) dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pad_in_data_i(pad_in_data_i),
        .strobe_i(strobe_i), .global_set_reset_n_i(global_set_reset_n_i),
        .pad_out_o(pad_out_o), .pad_tristate_ctl_o(pad_tristate_ctl_o),
        .raw_in_to_core_o(raw_in_to_core_o),
        .in_clock_tap_o(in_clock_tap_o),
        .strobe_delay_in_o(strobe_delay_in_o),
        .sdr_captured_in_o(sdr_captured_in_o),
        .ddr_captured_in_o(ddr_captured_in_o),
        .gearbox_pipe_rise_o(gearbox_pipe_rise_o),
        .gearbox_pipe_fall_o(gearbox_pipe_fall_o)
    );

    pic_ddr_source src
    (
        .clk_i(clk_i),
        .strobe_o(strobe_i),
        .pad_o(pad_in_data_i)
    );

    //////////////////////////////////////////////////////////////////////
    // Compare one value and count it
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t ns: saw %h, expected %h",
                     $time, seen, exp);
        end
    endtask

    // Classic Wishbone cycle; entered just after a rising edge
    task automatic xfer(input logic we, input logic [3:0] adr,
                        input logic [15:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {dat, dat};
        @(posedge clk_i);
        // Hold the request until ack is sampled; bounded so a hang shows
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50)
            fails++;
        rdata = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [3:0] adr, input logic [15:0] exp);
        xfer(1'b0, adr, 16'h0000);
        check(rdata, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog: the whole run needs well under 20000 cycles
    initial
    begin
        #200000;
        fails++;
        tally_and_finish();
    end

    //////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        tick(16);
        rst_i <= 1'b0;
        tick(3);
        // Reset contents, reserved bits and an unmapped address
        rd(PIC_ADDR_CTRL, PIC_RST_CTRL);
        rd(PIC_ADDR_OUT, PIC_RST_OUT);
        rd(PIC_ADDR_DELAY, PIC_RST_DELAY);
        check(16'(pad_tristate_ctl_o), 16'h0000);
        xfer(1'b1, PIC_ADDR_DELAY, 16'hFFFF);
        rd(PIC_ADDR_DELAY, PIC_MASK_DELAY);
        // Upper lane only: the delay code lives in the low byte, so no change
        wb_sel_i <= 4'h2;
        xfer(1'b1, PIC_ADDR_DELAY, 16'h0000);
        wb_sel_i <= 4'hF;
        rd(PIC_ADDR_DELAY, PIC_MASK_DELAY);
        xfer(1'b1, 4'h2, 16'hFFFF);
        rd(4'h2, 16'h0000);
        // Bypass path of both slices, clock tap follows the true pad
        for (int v = 1; v < 3; v++)
        begin
            src.hold(2'(v));
            tick(6);
            check(16'(raw_in_to_core_o), 16'(v));
            check(16'({in_clock_tap_o, strobe_delay_in_o}), 16'(3*v[0]));
        end
        // Dynamic delay of 16 taps holds a new level back
        xfer(1'b1, PIC_ADDR_CTRL, 16'h002D);
        src.hold(2'h0);
        tick(30);
        check(16'(sdr_captured_in_o), 16'h0000);
        src.hold(2'h3);
        tick(8);
        check(16'(sdr_captured_in_o), 16'h0000);
        tick(24);
        check(16'(sdr_captured_in_o), 16'h0003);
        // Fixed delay still lags the plain sync path
        xfer(1'b1, PIC_ADDR_CTRL, 16'h0025);
        src.hold(2'h0);
        tick(5);
        check(16'(sdr_captured_in_o), 16'h0003);
        tick(10);
        check(16'(sdr_captured_in_o), 16'h0000);
        // Clock enable low freezes the capture
        xfer(1'b1, PIC_ADDR_CTRL, 16'h0001);
        src.hold(2'h3);
        tick(10);
        check(16'(sdr_captured_in_o), 16'h0000);
        xfer(1'b1, PIC_ADDR_CTRL, 16'h0021);
        tick(8);
        check(16'(sdr_captured_in_o), 16'h0003);
        // Local, then global set/reset clear the capture
        xfer(1'b1, PIC_ADDR_CTRL, 16'h0061);
        tick(2);
        check(16'(sdr_captured_in_o), 16'h0000);
        xfer(1'b1, PIC_ADDR_CTRL, 16'h0021);
        global_set_reset_n_i <= 1'b0;
        tick(8);
        check(16'(sdr_captured_in_o), 16'h0000);
        global_set_reset_n_i <= 1'b1;
        tick(8);
        check(16'(sdr_captured_in_o), 16'h0003);
        // SDR pad drive, then the pair driven as a differential output
        xfer(1'b1, PIC_ADDR_OUT, 16'h000A);
        tick(2);
        check(16'({pad_tristate_ctl_o, pad_out_o}), 16'h000F);
        xfer(1'b1, PIC_ADDR_CTRL, 16'h00A1);
        tick(2);
        check(16'(pad_out_o), 16'h0001);
        xfer(1'b1, PIC_ADDR_OUT, 16'h001A);
        tick(2);
        check(16'(pad_tristate_ctl_o), 16'h0000);
        // DDR pad drive: data and enable halves alternate every cycle
        xfer(1'b1, PIC_ADDR_CTRL, 16'h01A1);
        xfer(1'b1, PIC_ADDR_OUT, 16'h0021);
        tick(2);
        rdata = 16'({pad_tristate_ctl_o, pad_out_o});
        tick(1);
        check(16'({pad_tristate_ctl_o, pad_out_o}) ^ rdata, 16'h000F);
        check(16'(rdata[0] ^ rdata[2]), 16'h0001);
        // DDR burst with transfer on the strobe fall
        xfer(1'b1, PIC_ADDR_CTRL, 16'h0022);
        src.burst(16'h0039, 16'h000E, 3);
        tick(10);
        check(16'(ddr_captured_in_o), 16'h0005);
        // SDR capture froze at 3 when the mode left SDR; pads released to 3
        rd(PIC_ADDR_INDATA, 16'h005F);
        check(rdata & 16'hFFF3, 16'h0053);
        // Polarity 1 transfers on the next rise: last pair stays behind
        xfer(1'b1, PIC_ADDR_CTRL, 16'h0032);
        src.burst(16'h0039, 16'h000E, 3);
        tick(10);
        check(16'(ddr_captured_in_o), 16'h000E);
        // Gearbox: two strobe periods of the true pad become four bits
        xfer(1'b1, PIC_ADDR_CTRL, 16'h0023);
        src.burst(16'h0039, 16'h000E, 2);
        tick(10);
        check(16'({gearbox_pipe_fall_o,gearbox_pipe_rise_o}), 16'h0009);
        tally_and_finish();
    end
endmodule
